// ---- rtl/mouse_joystick_counter_port.sv ----
// mouse/joystick counter port: receives the serial port frame, keeps
// four quadrature counters, latches the jumper byte and serves the
// register port.
// assumes an external shifter that presents pins and jumpers msb first
// on serial_port_input, one bit per colour clock phase.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps

// Overview of operation
// - each count register holds Y high, X low
// - each counter driven by one quadrature pair
// - low two counter bits follow pins
// - movement bits come first in frame
// - one frame every 16 bus cycles
// - msb first, pairs at positions 15 to 8
// - left/right on bit 1, xor gives forward/back
// - test write loads all four counters' upper bits
// - low byte identifies revision and features
// - revision field counts down from hex F
// - upper byte holds last eight frame bits
// - one 16-bit serial port feeds everything
module mouse_joystick_counter_port #(
  parameter logic [3:0] REV_LEVEL = 4'hf, // arbitrary revision value
  parameter bit ADV_FEATURES = 1'b0,
  parameter bit ENH_FEATURES = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [joy_port_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [joy_port_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [joy_port_pkg::DATA_W-1:0] reg_rdata,
  // serial port
  input wire logic colour_clock,
  input wire logic serial_port_input,
  output logic shifter_load,
  // decoded status
  output joy_port_pkg::joy_dir_t left_dir,
  output joy_port_pkg::joy_dir_t right_dir,
  output logic [7:0] jumpers
);

  localparam int CW = joy_port_pkg::CNT_W;

  // frame from the receiver
  joy_port_pkg::serial_frame_t frame;
  logic frame_valid;

  // counters: 0 left Y, 1 left X, 2 right Y, 3 right X
  logic [CW-1:0] count [joy_port_pkg::NUM_COUNTERS];
  logic [CW-3:0] test_value [joy_port_pkg::NUM_COUNTERS];

  // bus decode
  logic hit_left;
  logic hit_right;
  logic hit_test;
  logic hit_rev;
  logic test_load;

  // read path
  logic [15:0] left_counts;
  logic [15:0] right_counts;
  logic [15:0] rev_word;
  logic [7:0] rev_low;
  logic [15:0] rdata_next;

  // latched jumper byte
  logic [7:0] jumpers_reg;

  // direction decode
  joy_port_pkg::joy_dir_t left_dir_next;
  joy_port_pkg::joy_dir_t right_dir_next;

  // serial frame receiver
  serial_frame_rx u_rx (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .colour_clock(colour_clock),
    .serial_port_input(serial_port_input),
    .shifter_load(shifter_load),
    .frame(frame),
    .frame_valid(frame_valid)
  );

  // address decode; only the exact offsets respond
  assign hit_left = reg_addr == joy_port_pkg::LEFT_PORT_COUNTS_OFS;
  assign hit_right = reg_addr == joy_port_pkg::RIGHT_PORT_COUNTS_OFS;
  assign hit_test = reg_addr == joy_port_pkg::COUNTER_TEST_LOAD_OFS;
  assign hit_rev = reg_addr == joy_port_pkg::REVISION_AND_JUMPERS_OFS;
  assign test_load = reg_write && hit_test;

  // test word split: Y from the high byte, X from the low byte
  assign test_value[0] =
    reg_wdata[joy_port_pkg::TEST_Y_MSB:joy_port_pkg::TEST_Y_LSB];
  assign test_value[1] =
    reg_wdata[joy_port_pkg::TEST_X_MSB:joy_port_pkg::TEST_X_LSB];
  assign test_value[2] =
    reg_wdata[joy_port_pkg::TEST_Y_MSB:joy_port_pkg::TEST_Y_LSB];
  assign test_value[3] =
    reg_wdata[joy_port_pkg::TEST_X_MSB:joy_port_pkg::TEST_X_LSB];

  // four counters, each fed by its pair from the movement byte
  for (genvar k = 0; k < joy_port_pkg::NUM_COUNTERS; k++) begin : g_cnt
    quad_counter #(
      .WIDTH(CW)
    ) u_cnt (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .update(frame_valid),
      .pin_a(frame.movement[7-2*k]),
      .pin_q(frame.movement[6-2*k]),
      .test_load(test_load),
      .test_value(test_value[k]),
      .count(count[k])
    );
  end

  // count words: Y in the upper byte, X in the lower byte
  assign left_counts = {count[0], count[1]};
  assign right_counts = {count[2], count[3]};

  // revision byte: field counts down, feature bits active low
  assign rev_low = {REV_LEVEL, 1'b1, ~ADV_FEATURES, ~ENH_FEATURES, 1'b1};
  assign rev_word = {jumpers_reg, rev_low};

  // jumper byte latched from the tail of each frame
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      jumpers_reg <= joy_port_pkg::JUMPERS_RST;
    end else if (frame_valid) begin
      jumpers_reg <= frame.jumpers;
    end
  end

  // read mux; reads only select, they never touch state
  always_comb begin
    rdata_next = joy_port_pkg::RDATA_RST;
    if (reg_read) begin
      if (hit_left) rdata_next = left_counts;
      else if (hit_right) rdata_next = right_counts;
      else if (hit_rev) rdata_next = rev_word;
      else rdata_next = joy_port_pkg::RDATA_RST;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) reg_rdata <= joy_port_pkg::RDATA_RST;
    else reg_rdata <= rdata_next;
  end

  // directions: pins are active low, counters present them active high
  always_comb begin
    left_dir_next.left = count[0][1];
    left_dir_next.right = count[1][1];
    left_dir_next.forward = count[0][1] ^ count[0][0];
    left_dir_next.back = count[1][1] ^ count[1][0];
    right_dir_next.left = count[2][1];
    right_dir_next.right = count[3][1];
    right_dir_next.forward = count[2][1] ^ count[2][0];
    right_dir_next.back = count[3][1] ^ count[3][0];
  end

  // registered direction outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      left_dir <= '0;
      right_dir <= '0;
    end else begin
      left_dir <= left_dir_next;
      right_dir <= right_dir_next;
    end
  end

  // registered jumper output
  always_ff @(posedge clk_sys) begin
    if (sys_rst) jumpers <= joy_port_pkg::JUMPERS_RST;
    else jumpers <= jumpers_reg;
  end

endmodule : mouse_joystick_counter_port

// ---- rtl/joy_port_pkg.sv ----
// package for the mouse/joystick counter port: offsets, field positions,
// reset values, frame timing and the structs that carry frame contents.
// assumes a 16-bit register port addressed by byte offset.
package joy_port_pkg;

  // register port geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [8:0] LEFT_PORT_COUNTS_OFS = 9'h00a;
  localparam logic [8:0] RIGHT_PORT_COUNTS_OFS = 9'h00c;
  localparam logic [8:0] COUNTER_TEST_LOAD_OFS = 9'h036;
  localparam logic [8:0] REVISION_AND_JUMPERS_OFS = 9'h07c;

  // counter geometry and field positions
  localparam int CNT_W = 8;
  localparam int NUM_COUNTERS = 4;
  localparam int TEST_Y_MSB = 15;
  localparam int TEST_Y_LSB = 10;
  localparam int TEST_X_MSB = 7;
  localparam int TEST_X_LSB = 2;

  // reset values
  localparam logic [CNT_W-3:0] CNT_UPPER_RST = 6'h00;
  localparam logic [1:0] CNT_PHASE_RST = 2'h0;
  localparam logic [7:0] JUMPERS_RST = 8'h00;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // serial frame timing, counted in colour clock phases
  localparam int FRAME_BITS = 16;
  localparam int BUS_CYCLES_PER_FRAME = 16;
  localparam int EDGES_PER_FRAME = 2 * BUS_CYCLES_PER_FRAME;
  localparam logic [4:0] EDGE_IDLE = 5'h1f;
  localparam logic [4:0] FIRST_SAMPLE_EDGE = 5'h02;
  localparam logic [4:0] LAST_SAMPLE_EDGE = 5'h11;

  // one received frame: movement bits first, then jumper bits
  typedef struct packed {
    logic [7:0] movement;
    logic [7:0] jumpers;
  } serial_frame_t;

  // decoded joystick directions, active high
  typedef struct packed {
    logic forward;
    logic back;
    logic left;
    logic right;
  } joy_dir_t;

endpackage : joy_port_pkg

// ---- rtl/serial_frame_rx.sv ----
// serial frame receiver: times one 16-bit frame per 16 colour clock
// cycles, pulses the external shifter load and samples one bit per phase.
// assumes colour_clock and serial_port_input are synchronous to clk_sys.
`timescale 1ns/100ps
module serial_frame_rx (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // link side
  input wire logic colour_clock,
  input wire logic serial_port_input,
  output logic shifter_load,
  // received frame
  output joy_port_pkg::serial_frame_t frame,
  output logic frame_valid
);
  logic cck_prev_reg;
  logic [4:0] edge_cnt_reg;
  logic [15:0] shift_reg;
  logic cck_edge;
  logic cck_rise;
  logic in_window;
  logic [4:0] next_edge;

  assign cck_edge = colour_clock != cck_prev_reg;
  assign cck_rise = colour_clock & ~cck_prev_reg;
  // window tested on the phase that is just beginning; idle wraps to 0
  assign next_edge = edge_cnt_reg + 5'h01;
  assign in_window = next_edge >= joy_port_pkg::FIRST_SAMPLE_EDGE &&
                     next_edge <= joy_port_pkg::LAST_SAMPLE_EDGE;

  // previous colour clock level for phase detection
  always_ff @(posedge clk_sys) begin
    if (sys_rst) cck_prev_reg <= 1'b0;
    else cck_prev_reg <= colour_clock;
  end

  // phase counter: a frame starts on a rising colour clock edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      edge_cnt_reg <= joy_port_pkg::EDGE_IDLE;
    end else if (cck_rise && edge_cnt_reg == joy_port_pkg::EDGE_IDLE) begin
      edge_cnt_reg <= 5'h00;
    end else if (cck_edge && edge_cnt_reg != joy_port_pkg::EDGE_IDLE) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
    end
  end

  // load pulse to the shifter at frame start
  always_ff @(posedge clk_sys) begin
    if (sys_rst) shifter_load <= 1'b0;
    else shifter_load <= cck_rise && edge_cnt_reg == joy_port_pkg::EDGE_IDLE;
  end

  // msb first, one shift per phase in the clock that sees it begin;
  // shifting on every clock would take each bit as often as a phase lasts
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shift_reg <= 16'h0000;
    end else if (cck_edge && in_window) begin
      shift_reg <= {shift_reg[14:0], serial_port_input};
    end
  end

  // the whole frame is handed over once its last bit is in
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= cck_edge && edge_cnt_reg == joy_port_pkg::LAST_SAMPLE_EDGE;
    end
  end

  assign frame = shift_reg;
endmodule : serial_frame_rx

// ---- rtl/quad_counter.sv ----
// one quadrature position counter: low two bits follow the pin pair,
// upper bits carry or borrow when the phase wraps.
// assumes pin_a and pin_q are the pin levels of one frame, active low.
`timescale 1ns/100ps
module quad_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // pin pair from the current frame
  input wire logic update,
  input wire logic pin_a,
  input wire logic pin_q,
  // test load of the upper bits
  input wire logic test_load,
  input wire logic [WIDTH-3:0] test_value,
  // count
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-3:0] upper_reg;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;

  // one step of the upper bits, sized to them
  localparam logic [WIDTH-3:0] STEP = (WIDTH-2)'(1);

  // refuse widths that leave no upper bits
  if (WIDTH < 3) begin : g_width_check
    $error("quad_counter needs at least 3 bits");
  end

  // bit1 is the inverted second pin, bit0 the xor of both pins
  assign phase_next = {~pin_q, pin_q ^ pin_a};

  // low bits mirror the pins every frame
  always_ff @(posedge clk_sys) begin
    if (sys_rst) phase_reg <= joy_port_pkg::CNT_PHASE_RST;
    else if (update) phase_reg <= phase_next;
  end

  // carry on 3 to 0, borrow on 0 to 3; test load wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      upper_reg <= joy_port_pkg::CNT_UPPER_RST;
    end else if (test_load) begin
      upper_reg <= test_value;
    end else if (update && phase_reg == 2'h3 && phase_next == 2'h0) begin
      upper_reg <= upper_reg + STEP;
    end else if (update && phase_reg == 2'h0 && phase_next == 2'h3) begin
      upper_reg <= upper_reg - STEP;
    end
  end

  assign count = {upper_reg, phase_reg};
endmodule : quad_counter

// ---- verification/joy_port_props.sv ----
// checker for the counter port: read data, decode and frame timing.
// assumes it is bound to the top module and sees its ports only.
`timescale 1ns/100ps
module joy_port_props #(
  parameter logic [3:0] REV_LEVEL = 4'hf,
  parameter bit ADV_FEATURES = 1'b0,
  parameter bit ENH_FEATURES = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // serial port and status
  input wire logic colour_clock,
  input wire logic serial_port_input,
  input wire logic shifter_load,
  input wire joy_port_pkg::joy_dir_t left_dir,
  input wire joy_port_pkg::joy_dir_t right_dir,
  input wire logic [7:0] jumpers
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [15:0] wdata_q;
  // decoded strobes
  wire rd_left = reg_read && reg_addr == 9'h00a;
  wire rd_right = reg_read && reg_addr == 9'h00c;
  wire rd_test = reg_read && reg_addr == 9'h036;
  wire rd_rev = reg_read && reg_addr == 9'h07c;
  wire wr_test = reg_write && reg_addr == 9'h036;
  // last write data
  always_ff @(posedge clk_sys) begin
    if (reg_write) begin
      wdata_q <= reg_wdata;
    end
  end
  a_rdata_idle:
    assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("read data left standing");
  a_rev_code:
    assert property (rd_rev |=> reg_rdata[7:0] ==
      {REV_LEVEL, 1'b1, ~ADV_FEATURES, ~ENH_FEATURES, 1'b1})
    else $error("revision byte wrong");
  a_jumper_byte:
    assert property (rd_rev |=> reg_rdata[15:8] == jumpers)
    else $error("jumper byte differs");
  a_test_wo:
    assert property (rd_test |=> reg_rdata == 16'h0000)
    else $error("test register readable");
  a_test_load:
    assert property (wr_test ##1 rd_left |=>
      reg_rdata[15:10] == wdata_q[15:10] && reg_rdata[7:2] == wdata_q[7:2])
    else $error("test load not applied");
  a_left_dirs:
    assert property (rd_left |=> left_dir == {reg_rdata[9] ^ reg_rdata[8],
      reg_rdata[1] ^ reg_rdata[0], reg_rdata[9], reg_rdata[1]})
    else $error("left directions wrong");
  a_right_dirs:
    assert property (rd_right |=> right_dir == {reg_rdata[9] ^ reg_rdata[8],
      reg_rdata[1] ^ reg_rdata[0], reg_rdata[9], reg_rdata[1]})
    else $error("right directions wrong");
  a_load_rise:
    assert property (shifter_load |->
      $past(colour_clock) && !$past(colour_clock, 2))
    else $error("load not after a rise");
  a_load_single:
    assert property (shifter_load |=> !shifter_load [*8])
    else $error("load pulse repeated");
  // main scenarios reached
  cover property (wr_test ##1 rd_left);
  cover property (rd_rev);
  cover property (shifter_load);
endmodule : joy_port_props

bind mouse_joystick_counter_port joy_port_props #(
  .REV_LEVEL(REV_LEVEL),
  .ADV_FEATURES(ADV_FEATURES),
  .ENH_FEATURES(ENH_FEATURES)
) props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .colour_clock(colour_clock),
  .serial_port_input(serial_port_input), .shifter_load(shifter_load),
  .left_dir(left_dir), .right_dir(right_dir), .jumpers(jumpers)
);

// ---- verification/serial_shifter_model.sv ----
// external shifter model: makes the colour clock, latches pins and
// jumpers at the load pulse and shifts them out msb first.
// assumes the port samples on clk_sys; pins are active low levels.
`timescale 1ns/100ps
module serial_shifter_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // pins and jumpers
  input wire logic [7:0] pins,
  input wire logic [7:0] jumper_set,
  // serial link
  input wire logic shifter_load,
  output logic colour_clock = 1'b0,
  output logic serial_port_input
);
  logic div = 1'b0;
  logic [4:0] phase = 5'h1f;
  logic [15:0] word = 16'hffff;
  // one phase per two clocks, phase 0 at every sixteenth rise
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      div <= 1'b0;
      colour_clock <= 1'b0;
      phase <= 5'h1f;
    end else begin
      div <= ~div;
      if (div) begin
        colour_clock <= ~colour_clock;
        phase <= phase + 5'h01;
      end
    end
  end
  // movement ahead of jumpers in one 16-bit word
  always @(posedge clk_sys) begin
    if (shifter_load) begin
      word <= {pins, jumper_set};
    end
  end
  // msb first on phases 2 to 17, filler toggles elsewhere
  assign serial_port_input = (phase >= 5'h02 && phase <= 5'h11) ?
    word[4'(5'h11 - phase)] : phase[0];
endmodule : serial_shifter_model

// ---- verification/mouse_joystick_counter_port_test.sv ----
// testbench: register reads and writes, quadrature frames, decode.
// assumes the shifter model drives colour clock and serial data.
`timescale 1ns/100ps
module mouse_joystick_counter_port_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic colour_clock;
  logic serial_port_input;
  logic shifter_load;
  joy_port_pkg::joy_dir_t left_dir;
  joy_port_pkg::joy_dir_t right_dir;
  logic [7:0] jumpers;
  logic [7:0] pins = 8'hff;
  logic [7:0] jset = 8'ha5;
  logic [7:0] cnt [4];
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // clock and cycle ceiling
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  mouse_joystick_counter_port uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .colour_clock(colour_clock),
    .serial_port_input(serial_port_input), .shifter_load(shifter_load),
    .left_dir(left_dir), .right_dir(right_dir), .jumpers(jumpers)
  );
  serial_shifter_model shifter (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins),
    .jumper_set(jset), .shifter_load(shifter_load),
    .colour_clock(colour_clock), .serial_port_input(serial_port_input)
  );
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [15:0] s, input logic [15:0] e,
                       input string n);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [15:0] e,
                    input string n);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 check(reg_rdata, e, n);
    @(posedge clk_sys);
  endtask : rd
  // expected step of one counter to new low bits l
  function automatic logic [7:0] step(input logic [7:0] c,
                                      input logic [1:0] l);
    logic [5:0] u;
    u = c[7:2];
    if (c[1:0] == 2'h3 && l == 2'h0)
      u = u + 6'h01;
    if (c[1:0] == 2'h0 && l == 2'h3)
      u = u - 6'h01;
    return {u, l};
  endfunction : step
  function automatic logic [15:0] dirs(input logic [7:0] y, x);
    return {12'h000, y[1] ^ y[0], x[1] ^ x[0], y[1], x[1]};
  endfunction : dirs
  task automatic check_all();
    rd(9'h00a, {cnt[0], cnt[1]}, "left counts");
    rd(9'h00c, {cnt[2], cnt[3]}, "right counts");
    check({12'h000, left_dir}, dirs(cnt[0], cnt[1]), "left dir");
    check({12'h000, right_dir}, dirs(cnt[2], cnt[3]), "right dir");
  endtask : check_all
  // lv holds new low bits of left y, left x, right y, right x
  task automatic frame(input logic [7:0] lv);
    logic [1:0] nl;
    for (int i = 0; i < 4; i++) begin
      nl = lv[7-2*i -: 2];
      pins[7-2*i -: 2] <= {nl[0] ^ ~nl[1], ~nl[1]};
      cnt[i] = step(cnt[i], nl);
    end
    repeat (130) @(posedge clk_sys);
    check_all();
  endtask : frame
  // main sequence
  initial begin
    cnt = '{default: 8'h00};
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (130) @(posedge clk_sys);
    check_all();
    rd(9'h07c, {jset, 8'hff}, "revision");
    rd(9'h07c, {jset, 8'hff}, "revision again");
    check({8'h00, jumpers}, {8'h00, jset}, "jumpers");
    rd(9'h000, 16'h0000, "unmapped");
    rd(9'h036, 16'h0000, "test read");
    wr(9'h00a, 16'h1234);
    // let an edge pass so the write strobe is not assigned twice at once
    @(posedge clk_sys);
    wr(9'h036, 16'hfcfc);
    cnt = '{default: 8'hfc};
    check_all();
    frame(8'b01_11_01_10);
    frame(8'b10_10_10_00);
    frame(8'b11_01_11_11);
    frame(8'b00_00_00_11);
    jset <= 8'h3c;
    repeat (130) @(posedge clk_sys);
    rd(9'h07c, {8'h3c, 8'hff}, "new jumpers");
    wrap_up();
  end
endmodule : mouse_joystick_counter_port_test
